// *** src/nvram_host.sv ***
// Host controller driving the pins of a byte-wide nonvolatile SRAM with clock.
// Assumes the device pins are wired one to one; data_lines and save_busy_n
// are resolved by the surrounding wiring from the _oe_n enables.
// Contract
// - Data moves both ways over one 8-bit bus.
// - Chip select low selects the device; high means it ignores the bus.
// - With write enable low, the byte is written at chip-select rise.
// - Pulling save/busy low from outside starts a save.
`timescale 1ns/100ps
module nvram_host #(
    parameter int ADDR_W = nvram_host_pkg::ADDR_W,
    parameter int DATA_W = nvram_host_pkg::DATA_W
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    // User request side
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire logic req_write_i,
    input wire logic [ADDR_W-1:0] req_addr_i,
    input wire logic [DATA_W-1:0] req_wdata_i,
    output logic rsp_valid_o,
    output logic [DATA_W-1:0] rsp_rdata_o,
    input wire logic save_req_i,
    output logic save_ack_o,
    output logic dev_busy_o,
    input wire logic irq_high_mode_i,
    output logic irq_o,
    // Device pins
    output logic [ADDR_W-1:0] byte_address_lines_o,
    output logic chip_sel_n_o,
    output logic write_en_n_o,
    output logic out_en_n_o,
    input wire logic [DATA_W-1:0] data_lines_i,
    output logic [DATA_W-1:0] data_lines_o,
    output logic data_lines_oe_n_o,
    input wire logic save_busy_n_i,
    output logic save_busy_n_o,
    output logic save_busy_oe_n_o,
    input wire logic int_pin_i
);
    typedef enum logic [2:0] {S_IDLE, S_SETUP, S_STROBE, S_HOLD, S_SAVE} state_t;
    typedef struct packed {
        state_t state;
        nvram_host_pkg::op_t op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] rdata;
        logic [7:0] cnt;
        logic rsp;
        logic ack;
        logic cs_n;
        logic we_n;
        logic oe_n;
        logic drv_n;
        logic save_drv_n;
    } host_t;
    host_t st_r;
    host_t st_nxt;

    logic busy_lvl_n;
    logic int_lvl;

    // Reset to busy: no request is taken until the pin has been seen high,
    // so a restore still running when reset lifts is never cut into.
    pin_sync #(.RST_VAL(1'b0)) u_busy_sync (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .pin_i(save_busy_n_i),
        .level_o(busy_lvl_n)
    );

    pin_sync #(.RST_VAL(1'b0)) u_int_sync (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .pin_i(int_pin_i),
        .level_o(int_lvl)
    );

    // Read data is only sampled after the strobe settled, so one bank of
    // synchronisers per bit is cheaper than a handshake on the whole byte.
    logic [DATA_W-1:0] rd_lvl;
    genvar gi;
    generate
        for (gi = 0; gi < DATA_W; gi++) begin : g_rd
            pin_sync #(.RST_VAL(1'b0)) u_rd_sync (
                .clk_i(clk_i),
                .nrst_i(nrst_i),
                .pin_i(data_lines_i[gi]),
                .level_o(rd_lvl[gi])
            );
        end
    endgenerate

    localparam logic [7:0] SETUP_CNT = 8'(nvram_host_pkg::SETUP_CYC);
    // Strobe also covers the synchroniser delay for read data
    localparam logic [7:0] STROBE_CNT = 8'(nvram_host_pkg::STROBE_CYC + 4);
    localparam logic [7:0] HOLD_CNT = 8'(nvram_host_pkg::HOLD_CYC);
    localparam logic [7:0] SAVE_CNT = 8'(nvram_host_pkg::SAVE_REQ_CYC);

    always_comb begin
        st_nxt = st_r;
        st_nxt.rsp = 1'b0;
        st_nxt.ack = 1'b0;
        unique case (st_r.state)
            S_IDLE: begin
                st_nxt.cnt = nvram_host_pkg::CNT_RST;
                // Device busy saving or restoring: hold off all accesses
                if (busy_lvl_n) begin
                    if (save_req_i) begin
                        st_nxt.state = S_SAVE;
                        st_nxt.save_drv_n = 1'b0;
                    end else if (req_valid_i) begin
                        st_nxt.state = S_SETUP;
                        st_nxt.op = req_write_i ? nvram_host_pkg::OP_WRITE
                                                : nvram_host_pkg::OP_READ;
                        st_nxt.addr = req_addr_i;
                        st_nxt.wdata = req_wdata_i;
                        st_nxt.we_n = ~req_write_i;
                        st_nxt.drv_n = ~req_write_i;
                    end
                end
            end
            S_SETUP: begin
                st_nxt.cnt = st_r.cnt + 8'h01;
                if (st_r.cnt + 8'h01 >= SETUP_CNT) begin
                    st_nxt.cnt = nvram_host_pkg::CNT_RST;
                    st_nxt.state = S_STROBE;
                    // Address and write enable settle before select falls
                    st_nxt.cs_n = 1'b0;
                    st_nxt.oe_n = (st_r.op == nvram_host_pkg::OP_WRITE);
                end
            end
            S_STROBE: begin
                st_nxt.cnt = st_r.cnt + 8'h01;
                if (st_r.cnt + 8'h01 >= STROBE_CNT) begin
                    st_nxt.cnt = nvram_host_pkg::CNT_RST;
                    st_nxt.state = S_HOLD;
                    st_nxt.cs_n = 1'b1;
                    st_nxt.oe_n = 1'b1;
                    if (st_r.op == nvram_host_pkg::OP_READ) begin
                        st_nxt.rdata = rd_lvl;
                    end
                end
            end
            S_HOLD: begin
                st_nxt.cnt = st_r.cnt + 8'h01;
                if (st_r.cnt + 8'h01 >= HOLD_CNT) begin
                    st_nxt.cnt = nvram_host_pkg::CNT_RST;
                    st_nxt.state = S_IDLE;
                    st_nxt.we_n = 1'b1;
                    st_nxt.drv_n = 1'b1;
                    st_nxt.rsp = 1'b1;
                end
            end
            S_SAVE: begin
                st_nxt.cnt = st_r.cnt + 8'h01;
                if (st_r.cnt + 8'h01 >= SAVE_CNT) begin
                    st_nxt.cnt = nvram_host_pkg::CNT_RST;
                    // Release; the pull-up and the device's busy drive take over
                    st_nxt.save_drv_n = 1'b1;
                    st_nxt.ack = 1'b1;
                    st_nxt.state = S_IDLE;
                end
            end
            default: begin
                // Unused codes fall back to idle with every strobe released
                st_nxt.state = S_IDLE;
                st_nxt.cs_n = 1'b1;
                st_nxt.oe_n = 1'b1;
                st_nxt.we_n = 1'b1;
                st_nxt.drv_n = 1'b1;
                st_nxt.save_drv_n = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_r.state <= S_IDLE;
            st_r.op <= nvram_host_pkg::OP_READ;
            st_r.addr <= '0;
            st_r.wdata <= nvram_host_pkg::DATA_RST;
            st_r.rdata <= nvram_host_pkg::DATA_RST;
            st_r.cnt <= nvram_host_pkg::CNT_RST;
            st_r.rsp <= 1'b0;
            st_r.ack <= 1'b0;
            st_r.cs_n <= 1'b1;
            st_r.we_n <= 1'b1;
            st_r.oe_n <= 1'b1;
            st_r.drv_n <= 1'b1;
            st_r.save_drv_n <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign req_ready_o = (st_r.state == S_IDLE) && busy_lvl_n && !save_req_i;
    assign rsp_valid_o = st_r.rsp;
    assign rsp_rdata_o = st_r.rdata;
    assign save_ack_o = st_r.ack;
    assign dev_busy_o = ~busy_lvl_n;
    // Interrupt source and polarity are programmed in the device; host
    // only needs to know which level means asserted.
    assign irq_o = irq_high_mode_i ? int_lvl : ~int_lvl;
    assign byte_address_lines_o = st_r.addr;
    assign chip_sel_n_o = st_r.cs_n;
    assign write_en_n_o = st_r.we_n;
    assign out_en_n_o = st_r.oe_n;
    assign data_lines_o = st_r.wdata;
    assign data_lines_oe_n_o = st_r.drv_n;
    assign save_busy_n_o = 1'b0;
    assign save_busy_oe_n_o = st_r.save_drv_n;
endmodule : nvram_host

// *** common/nvram_host_pkg.sv ***
// Constants for the host controller of a byte-wide nonvolatile SRAM with clock.
// Assumes a 100 MHz system clock; all times are counted in that clock.
package nvram_host_pkg;
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int ARRAY_BYTES = 32768;
    localparam int CLOCK_REGS = 16;
    localparam int CLK_PERIOD_NS = 10;
    // Access phase times in ns; least times, so counts round up
    localparam int SETUP_NS = 10;
    localparam int STROBE_NS = 50;
    localparam int HOLD_NS = 10;
    localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Low pulse driven on the save/busy pin to request a save
    localparam int SAVE_REQ_NS = 100;
    localparam int SAVE_REQ_CYC = (SAVE_REQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] CNT_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;
    typedef enum logic {OP_READ, OP_WRITE} op_t;
endpackage : nvram_host_pkg

// *** src/pin_sync.sv ***
// Three-flop synchroniser for one pin; output changes once stages two and three agree.
// Assumes the pin is asynchronous to clk_i.
`timescale 1ns/100ps
module pin_sync #(
    parameter logic RST_VAL = 1'b1
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic pin_i,
    output logic level_o
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } sync_t;
    sync_t st_r;
    sync_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = pin_i;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        if (st_r.s2 == st_r.s3) begin
            st_nxt.lvl = st_r.s3;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_r <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign level_o = st_r.lvl;
endmodule : pin_sync

// *** bench/nvram_host_assertions.sv ***
// Pin sequencing checks for nvram_host.
// Bound onto nvram_host; sees its ports only.
`timescale 1ns/100ps
module nvram_host_assertions (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic req_ready_o,
    input wire logic rsp_valid_o,
    input wire logic save_ack_o,
    input wire logic dev_busy_o,
    input wire logic [14:0] byte_address_lines_o,
    input wire logic chip_sel_n_o,
    input wire logic write_en_n_o,
    input wire logic out_en_n_o,
    input wire logic [7:0] data_lines_o,
    input wire logic data_lines_oe_n_o,
    input wire logic save_busy_oe_n_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    sequence s_sel;
        (!chip_sel_n_o)[*8] ##1 !chip_sel_n_o ##1 chip_sel_n_o;
    endsequence
    sequence s_pull;
        (!save_busy_oe_n_o)[*8] ##1 (!save_busy_oe_n_o)[*2] ##1
            (save_busy_oe_n_o && save_ack_o);
    endsequence
    a_strobe_len: assert property ($fell(chip_sel_n_o) |-> s_sel)
        else $error("select length wrong");
    a_answer_time: assert property ($rose(chip_sel_n_o) |=> rsp_valid_o)
        else $error("no answer after deselect");
    a_write_data: assert property (!chip_sel_n_o && !write_en_n_o |->
        !data_lines_oe_n_o && $stable(data_lines_o))
        else $error("write data not held");
    a_read_release: assert property (!out_en_n_o |-> data_lines_oe_n_o && write_en_n_o)
        else $error("host drives in read");
    a_idle_release: assert property (out_en_n_o && write_en_n_o |-> data_lines_oe_n_o)
        else $error("host drives when idle");
    a_addr_hold: assert property (!chip_sel_n_o |-> $stable(byte_address_lines_o))
        else $error("address moved while selected");
    a_save_pulse: assert property ($fell(save_busy_oe_n_o) |-> s_pull)
        else $error("save pulse wrong");
    a_busy_block: assert property ($fell(chip_sel_n_o) |->
        $past(req_ready_o, 2) && !$past(dev_busy_o, 2))
        else $error("ready while busy");
    a_save_quiet: assert property (!save_busy_oe_n_o |-> chip_sel_n_o)
        else $error("select during save pull");
endmodule : nvram_host_assertions

bind nvram_host nvram_host_assertions i_nvram_host_assertions (.clk_i, .nrst_i, .req_ready_o,
    .rsp_valid_o, .save_ack_o, .dev_busy_o, .byte_address_lines_o, .chip_sel_n_o,
    .write_en_n_o, .out_en_n_o, .data_lines_o, .data_lines_oe_n_o, .save_busy_oe_n_o);

// *** bench/nvram_dev_model.sv ***
// Behavioural device: byte array and save/busy pin.
// Bench resolves shared wires and adds the pull-up.
`timescale 1ns/100ps
module nvram_dev_model (
    input wire logic clk_i,
    input wire logic [14:0] addr_i,
    input wire logic cs_n_i,
    input wire logic we_n_i,
    input wire logic oe_n_i,
    input wire logic [7:0] dq_i,
    output logic [7:0] dq_o,
    output logic dq_drv_o,
    input wire logic busy_pin_i,
    output logic busy_drv_o,
    input wire logic pwr_fail_i,
    input wire logic alarm_en_i,
    input wire logic alarm_rpt_i,
    output logic alarm_o,
    output int saves_o
);
    logic [7:0] mem [0:32767];
    logic [14:0] addr_l;
    int busy_cnt = 16; // Restore runs first, so early accesses must wait
    int save_cnt = 0;
    int tick_cnt = 0;
    logic alarm_q = 1'b0;
    logic fired = 1'b0;
    assign saves_o = save_cnt;
    assign alarm_o = alarm_q;
    // One calendar step per 32 clocks stands in for the crystal to keep runs short
    always @(posedge clk_i) begin
        tick_cnt <= tick_cnt == 31 ? 0 : tick_cnt + 1;
        if (!alarm_en_i) begin
            alarm_q <= 1'b0;
            fired <= 1'b0;
        end else if (tick_cnt == 31) begin
            // Once: a single step-long pulse; repeat: a pulse every other step
            alarm_q <= alarm_rpt_i ? !alarm_q : !fired;
            fired <= 1'b1;
        end
    end
    assign dq_drv_o = !cs_n_i && we_n_i && !oe_n_i;
    assign dq_o = mem[addr_i];
    assign busy_drv_o = busy_cnt != 0 || pwr_fail_i;
    always @(negedge cs_n_i) addr_l = addr_i;
    always @(posedge cs_n_i) if (!we_n_i) mem[addr_l] = dq_i;
    always @(posedge clk_i) begin
        if (busy_cnt != 0) busy_cnt <= busy_cnt - 1;
        else if (!busy_pin_i && !pwr_fail_i) begin
            save_cnt <= save_cnt + 1;
            busy_cnt <= 20;
        end
    end
endmodule : nvram_dev_model

// *** bench/tb_top.sv ***
// Self-checking bench for nvram_host with a behavioural device.
// Pull-up on save/busy is modelled here; the interrupt pin is driven at the selected polarity.
`timescale 1ns/100ps
module tb_top;
    logic clk_i = 0, nrst_i = 0, req_valid_i = 0, req_write_i = 0, save_req_i = 0;
    logic irq_high_mode_i = 1, irq_src = 0, pwr_fail = 0, hb, int_pin;
    logic req_ready_o, rsp_valid_o, save_ack_o, dev_busy_o, irq_o, cs_n, we_n, oe_n;
    logic dq_oe_n, hb_o, hb_oe_n, dq_drv, busy_drv;
    logic alarm_en = 0, alarm_rpt = 0, alarm, irq_seen = 0;
    logic [14:0] req_addr_i = 0, addr;
    logic [7:0] req_wdata_i = 0, rsp_rdata_o, dq_host, dq_dev, dq;
    logic [8:0] q [$];
    logic [7:0] ref_mem [int];
    int saves, num_errors = 0, n_checks = 0, irq_rises = 0;
    assign dq = !dq_oe_n ? dq_host : dq_drv ? dq_dev : {8{clk_i}};
    assign hb = (hb_oe_n || hb_o) && !busy_drv;
    assign int_pin = irq_high_mode_i ? (irq_src || alarm) : !(irq_src || alarm);
    nvram_host i_nvram_host (.clk_i, .nrst_i, .req_valid_i, .req_ready_o, .req_write_i,
        .req_addr_i, .req_wdata_i, .rsp_valid_o, .rsp_rdata_o, .save_req_i, .save_ack_o,
        .dev_busy_o, .irq_high_mode_i, .irq_o, .byte_address_lines_o(addr),
        .chip_sel_n_o(cs_n), .write_en_n_o(we_n), .out_en_n_o(oe_n), .data_lines_i(dq),
        .data_lines_o(dq_host), .data_lines_oe_n_o(dq_oe_n), .save_busy_n_i(hb),
        .save_busy_n_o(hb_o), .save_busy_oe_n_o(hb_oe_n), .int_pin_i(int_pin));
    nvram_dev_model i_nvram_dev_model (.clk_i, .addr_i(addr), .cs_n_i(cs_n), .we_n_i(we_n),
        .oe_n_i(oe_n), .dq_i(dq), .dq_o(dq_dev), .dq_drv_o(dq_drv), .busy_pin_i(hb),
        .busy_drv_o(busy_drv), .pwr_fail_i(pwr_fail), .alarm_en_i(alarm_en),
        .alarm_rpt_i(alarm_rpt), .alarm_o(alarm), .saves_o(saves));
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic access(input logic w, input logic [14:0] a, input logic [7:0] d);
        q.push_back({!w, w ? 8'h00 : ref_mem[a]});
        if (w) ref_mem[a] = d;
        req_valid_i <= 1'b1;
        req_write_i <= w;
        req_addr_i <= a;
        req_wdata_i <= d;
        do @(negedge clk_i); while (req_ready_o !== 1'b1);
        @(posedge clk_i);
    endtask : access
    task complete_run;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : complete_run
    // Results are judged off the edge, once registered outputs have settled
    always @(negedge clk_i) if (rsp_valid_o === 1'b1) begin
        logic [8:0] e;
        e = q.pop_front();
        if (e[8]) check("read byte", e[7:0], rsp_rdata_o);
    end
    // Counts interrupt rises so the alarm modes can be told apart
    always @(negedge clk_i) begin
        if (irq_o === 1'b1 && !irq_seen) irq_rises++;
        irq_seen = irq_o === 1'b1;
    end
    initial forever #5 clk_i = ~clk_i;
    initial begin
        #300000;
        num_errors++;
        complete_run();
    end
    initial begin
        logic [14:0] a [6];
        int rises0;
        void'($urandom(32'h8064));
        repeat (5) @(posedge clk_i);
        nrst_i <= 1'b1;
        repeat (6) @(negedge clk_i);
        check("busy at power-up", 8'h01, {7'h00, dev_busy_o});
        @(posedge clk_i);
        for (int i = 0; i < 6; i++) a[i] = i == 0 ? 15'h0000 : i == 1 ? 15'h7fff : 15'($urandom);
        for (int i = 0; i < 6; i++) access(1'b1, a[i], 8'($urandom));
        for (int i = 0; i < 6; i++) access(1'b0, a[i], 8'h00);
        req_valid_i <= 1'b0;
        repeat (14) @(posedge clk_i);
        save_req_i <= 1'b1;
        for (int i = 0; i < 30 && save_ack_o !== 1'b1; i++) @(negedge clk_i);
        check("save ack", 8'h01, {7'h00, save_ack_o});
        @(posedge clk_i);
        save_req_i <= 1'b0;
        repeat (3) @(negedge clk_i);
        check("save count", 8'h01, 8'(saves));
        check("busy in save", 8'h01, {7'h00, dev_busy_o});
        repeat (16) @(negedge clk_i);
        check("busy after save", 8'h00, {7'h00, dev_busy_o});
        @(posedge clk_i);
        pwr_fail <= 1'b1;
        repeat (6) @(negedge clk_i);
        check("busy in power loss", 8'h01, {7'h00, dev_busy_o});
        @(posedge clk_i);
        pwr_fail <= 1'b0;
        access(1'b0, a[1], 8'h00);
        req_valid_i <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            irq_high_mode_i <= i[1];
            irq_src <= i[0];
            repeat (6) @(negedge clk_i);
            check("irq", {7'h00, i[0]}, {7'h00, irq_o});
            @(posedge clk_i);
        end
        for (int m = 0; m < 2; m++) begin
            irq_src <= 1'b0;
            repeat (8) @(posedge clk_i);
            rises0 = irq_rises;
            alarm_rpt <= m[0];
            alarm_en <= 1'b1;
            repeat (256) @(posedge clk_i);
            alarm_en <= 1'b0;
            check("alarm pulses", m[0] ? 8'h04 : 8'h01, 8'(irq_rises - rises0));
        end
        check("pending answers", 8'h00, 8'(q.size()));
        complete_run();
    end
endmodule : tb_top
